// file: src/sadc_pkg.sv
package sadc_pkg;
  // ----------------------------------------
  // Widths and sequencing counts
  // ----------------------------------------
  localparam int RES_HI = 14;
  localparam int RES_LO = 12;
  localparam int WORD_W = 16;
  localparam logic [4:0] ACQ_EDGE = 5'h10;
  localparam logic [4:0] SHIFT_LAST = 5'h10;
  localparam logic [2:0] NAP_PULSES = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;
  localparam logic [1:0] LATE_DELAY = 2'h1;
  localparam int SYS_CLK_HZ = 20000000;

  typedef enum logic [1:0] {
    SADC_ACTIVE,
    SADC_NAP,
    SADC_SLEEP
  } sadc_pwr_t;
endpackage : sadc_pkg

// file: src/sadc_buf2.sv
`timescale 1ns/1ns
module sadc_buf2 #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, low
  input wire logic in_valid_i, // Word offered
  output logic in_ready_o, // Room available
  input wire logic [WIDTH-1:0] in_data_i, // Word in
  output logic out_valid_o, // Word held
  input wire logic out_ready_i, // Drain accepts
  output logic [WIDTH-1:0] out_data_o // Word out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sadc_buf2

// file: src/sadc_core.sv
`timescale 1ns/1ns
module sadc_core #(
  parameter int RES = 14 // Result width, 14 or 12
) (
  input wire logic sys_clk_i, // System clock, 20 MHz
  input wire logic rst_n_i, // Async reset, low
  input wire logic serial_clk_i, // Host serial clock pin
  input wire logic convert_start_i, // Convert-start strobe pin
  input wire logic late_start_i, // Strobe rose inside setup window
  input wire logic sample_valid_i, // Converter core offers a sample
  output logic sample_ready_o, // Buffer can take a sample
  input wire logic signed [RES:0] sample_diff_i, // Input difference, one bit headroom
  output logic serial_result_out_o, // Serial data out value
  output logic serial_result_oe_o, // Serial data out enable
  output logic acquiring_o, // Sample-and-hold tracking the input
  output logic nap_o, // Nap mode
  output logic sleep_o // Sleep mode
);
  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic sck_meta, sck_sync, sck_prev;
  logic cnv_meta, cnv_sync, cnv_prev;
  logic sck_rise, cnv_rise;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
      cnv_meta <= 1'b0;
      cnv_sync <= 1'b0;
      cnv_prev <= 1'b0;
    end else begin
      sck_meta <= serial_clk_i;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      cnv_meta <= convert_start_i;
      cnv_sync <= cnv_meta;
      cnv_prev <= cnv_sync;
    end
  end

  assign sck_rise = sck_sync && !sck_prev;
  assign cnv_rise = cnv_sync && !cnv_prev;

  // ----------------------------------------
  // Setup-miss flag synchroniser
  // ----------------------------------------
  logic late_meta, late_sync;

  // Same depth as the strobe chain, so the flag lines up with cnv_rise
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      late_meta <= 1'b0;
      late_sync <= 1'b0;
    end else begin
      late_meta <= late_start_i;
      late_sync <= late_meta;
    end
  end

  // ----------------------------------------
  // Saturation and sampling
  // ----------------------------------------
  function automatic logic [RES-1:0] sat_code(input logic signed [RES:0] d);
    logic [RES-1:0] r;
    r = d[RES-1:0];
    if (d[RES] != d[RES-1]) begin
      r = d[RES] ? {1'b1, {(RES-1){1'b0}}} : {1'b0, {(RES-1){1'b1}}};
    end
    return r;
  endfunction : sat_code

  logic buf_valid;
  logic buf_ready;
  logic [RES-1:0] buf_data;
  logic [RES-1:0] held;
  logic [RES-1:0] shift_word;
  logic [4:0] edge_cnt;
  logic [1:0] delay_cnt;
  logic running;
  sadc_pkg::sadc_pwr_t pwr;
  logic [2:0] idle_pulses;
  logic start_ok;
  logic step;
  logic last_step;

  // Buffer keeps a converter word while the output shifter is still busy
  sadc_buf2 #(
    .WIDTH(RES),
    .DEPTH(2)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(sample_valid_i && acquiring_o),
    .in_ready_o(sample_ready_o),
    .in_data_i(sat_code(sample_diff_i)),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  // Hold the oldest buffered sample at the strobe edge
  // Strobes in nap or sleep only count toward power-down
  assign start_ok = cnv_rise && pwr == sadc_pkg::SADC_ACTIVE;
  assign buf_ready = start_ok;
  // One counted serial edge, after any setup-miss slip is used up
  assign step = sck_rise && running && delay_cnt == 2'h0;
  assign last_step = step && (edge_cnt + 5'h1 == sadc_pkg::ACQ_EDGE);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held <= '0;
    end else if (buf_ready && buf_valid) begin
      held <= buf_data;
    end
  end

  // ----------------------------------------
  // Conversion sequencing and output shifter
  // ----------------------------------------
  // Sequencer: counts the serial edges of one conversion
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running <= 1'b0;
      edge_cnt <= '0;
      delay_cnt <= '0;
    end else if (start_ok) begin
      running <= 1'b1;
      edge_cnt <= '0;
      // Setup miss costs one serial edge before the first bit
      delay_cnt <= late_sync ? sadc_pkg::LATE_DELAY : 2'h0;
    end else if (sck_rise && running) begin
      if (delay_cnt != 2'h0) begin
        delay_cnt <= delay_cnt - 2'h1;
      end else begin
        edge_cnt <= edge_cnt + 5'h1;
      end
      if (last_step) begin
        // Stop until the next strobe so stray edges cannot wrap the count
        running <= 1'b0;
      end
    end
  end

  // Output word register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_word <= '0;
    end else if (start_ok) begin
      // Previous word goes out while the new sample converts
      shift_word <= held;
    end else if (step && edge_cnt < 5'(RES)) begin
      shift_word <= {shift_word[RES-2:0], 1'b0};
    end
  end

  // Data pin and its enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_result_out_o <= 1'b0;
      serial_result_oe_o <= 1'b0;
    end else if (start_ok) begin
      serial_result_oe_o <= 1'b0;
    end else if (step) begin
      if (edge_cnt < 5'(RES)) begin
        serial_result_out_o <= shift_word[RES-1];
        serial_result_oe_o <= 1'b1;
      end else begin
        serial_result_oe_o <= 1'b0;
      end
    end
  end

  // Sample-and-hold status
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acquiring_o <= 1'b1;
    end else if (start_ok) begin
      acquiring_o <= 1'b0;
    end else if (last_step) begin
      acquiring_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Power-down by counting idle strobes
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr <= sadc_pkg::SADC_ACTIVE;
      idle_pulses <= '0;
    end else if (sck_sync != sck_prev) begin
      idle_pulses <= '0;
      if (sck_rise) begin
        pwr <= sadc_pkg::SADC_ACTIVE;
      end
    end else if (cnv_rise) begin
      // Saturate so long strobe trains stay in sleep
      if (idle_pulses != 3'h7) begin
        idle_pulses <= idle_pulses + 3'h1;
      end
      if (idle_pulses + 3'h1 >= sadc_pkg::SLEEP_PULSES) begin
        pwr <= sadc_pkg::SADC_SLEEP;
      end else if (idle_pulses + 3'h1 == sadc_pkg::NAP_PULSES) begin
        pwr <= sadc_pkg::SADC_NAP;
      end
    end
  end

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  assign nap_o = (pwr == sadc_pkg::SADC_NAP);
  assign sleep_o = (pwr == sadc_pkg::SADC_SLEEP);
endmodule : sadc_core

// file: tb/sadc_core_checker.sv
`timescale 1ns/1ns
module sadc_core_checker (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic serial_clk_i, // Serial clock
  input wire logic convert_start_i, // Strobe
  input wire logic serial_result_out_o, // Data
  input wire logic serial_result_oe_o, // Enable
  input wire logic acquiring_o, // Tracking
  input wire logic nap_o, // Nap
  input wire logic sleep_o // Sleep
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_ONE_MODE: assert property (!(nap_o && sleep_o)) else $error("two modes");
  AST_OE_NOT_ACQ: assert property (serial_result_oe_o |-> !acquiring_o) else $error("oe in acq");
  AST_START: assert property ($rose(convert_start_i) && !nap_o && !sleep_o
    |-> ##[1:6] (!acquiring_o && !serial_result_oe_o)) else $error("no start");
  AST_QUIET: assert property ((!$changed(serial_clk_i) && !$changed(convert_start_i)) [*6]
    |=> $stable(serial_result_out_o) && $stable(serial_result_oe_o)) else $error("moved");
  AST_WAKE_SLEEP: assert property ($rose(serial_clk_i) && sleep_o
    |-> ##[1:6] !sleep_o) else $error("no wake");
  AST_WAKE_NAP: assert property ($rose(serial_clk_i) && nap_o |-> ##[1:6] !nap_o) else $error("no wake");
  AST_SLEEP_VIA_NAP: assert property ($rose(sleep_o) |-> $past(nap_o)) else $error("skip nap");
  AST_MODE_QUIET: assert property (nap_o || sleep_o
    |-> !serial_result_oe_o) else $error("oe in mode");
endmodule : sadc_core_checker
bind sadc_core sadc_core_checker u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk_i),
  .convert_start_i(convert_start_i), .serial_result_out_o(serial_result_out_o),
  .serial_result_oe_o(serial_result_oe_o), .acquiring_o(acquiring_o), .nap_o(nap_o), .sleep_o(sleep_o));

// file: tb/sadc_host_model.sv
`timescale 1ns/1ns
module sadc_host_model #(
  parameter int RES = 14
) (
  input wire logic sys_clk_i, // Clock
  input wire logic result_bit_i, // Data line
  output logic serial_clk_o = 1'b0, // Serial clock
  output logic convert_start_o = 1'b0, // Strobe
  output logic late_start_o = 1'b0 // Setup missed
);
  // 400 ns serial period, clock stands still between frames
  localparam int SETTLE_CYCLES = 40000; // 2 ms of 50 ns clock cycles
  task half;
    repeat (4) @(posedge sys_clk_i);
  endtask : half
  task pulse;
    @(posedge sys_clk_i);
    convert_start_o <= 1'b1;
    half;
    convert_start_o <= 1'b0;
    half;
  endtask : pulse
  task wake;
    @(posedge sys_clk_i);
    serial_clk_o <= 1'b1;
    half;
    serial_clk_o <= 1'b0;
    half;
  endtask : wake
  // Reference needs time after sleep before results are trusted
  task settle;
    repeat (SETTLE_CYCLES) @(posedge sys_clk_i);
  endtask : settle
  task frame(input logic late, output logic [RES-1:0] word);
    @(posedge sys_clk_i);
    late_start_o <= late;
    pulse;
    word = '0;
    for (int k = 1; k <= 16 + late; k++) begin
      serial_clk_o <= 1'b1;
      if (k >= 2 + late && k < 2 + late + RES) word = {word[RES-2:0], result_bit_i};
      half;
      serial_clk_o <= 1'b0;
      half;
    end
    late_start_o <= 1'b0;
  endtask : frame
endmodule : sadc_host_model

// file: tb/tb_serial_adc_conversion_interface.sv
`timescale 1ns/1ns
module tb_serial_adc_conversion_interface;
  localparam int RES = 14;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic signed [RES:0] sample_diff_i = '0;
  wire sck, start_pin, late, ready, res_bit, oe, acq, nap, sleep;
  wire res_line = oe ? res_bit : ~res_bit; // Released line never shows the last bit
  int err_total = 0;
  int check_count = 0;
  logic [RES:0] vin [4] = '{15'h3fff, 15'h4000, 15'h0123, 15'h7ffe};
  logic [RES-1:0] vexp [5] = '{14'h0000, 14'h1fff, 14'h2000, 14'h0123, 14'h3ffe};
  always #25 sys_clk_i = ~sys_clk_i;
  sadc_core #(.RES(RES)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .serial_clk_i(sck),
    .convert_start_i(start_pin), .late_start_i(late), .sample_valid_i(sample_valid_i), .sample_ready_o(ready),
    .sample_diff_i(sample_diff_i), .serial_result_out_o(res_bit), .serial_result_oe_o(oe), .acquiring_o(acq),
    .nap_o(nap), .sleep_o(sleep));
  sadc_host_model #(.RES(RES)) host (.sys_clk_i(sys_clk_i), .result_bit_i(res_line), .serial_clk_o(sck),
    .convert_start_o(start_pin), .late_start_o(late));
  // ----------------------------------------
  // Checks and drivers
  // ----------------------------------------
  task close_out;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task chk_w(input logic [RES-1:0] got, input logic [RES-1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_w
  task chk_f(input logic got, input logic exp);
    chk_w({13'h0000, got}, {13'h0000, exp});
  endtask : chk_f
  task push(input logic [RES:0] d);
    int i;
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b1;
    sample_diff_i <= d;
    i = 0;
    do begin
      @(negedge sys_clk_i);
      i++;
    end while (!(ready === 1'b1 && acq === 1'b1) && i < 400);
    if (i >= 400) begin
      err_total++;
      close_out;
    end
    @(posedge sys_clk_i);
    sample_valid_i <= 1'b0;
  endtask : push
  task t_stream;
    logic [RES-1:0] w;
    push(vin[0]);
    push(vin[1]);
    @(negedge sys_clk_i);
    chk_f(ready, 1'b0); // Two-entry buffer full
    for (int k = 0; k < 5; k++) begin
      host.frame(k == 2, w);
      chk_w(w, vexp[k]);
      chk_f(oe, 1'b0);
      chk_f(acq, 1'b1);
      if (k < 2) push(vin[k+2]);
    end
    $display("t_stream done");
  endtask : t_stream
  task t_power;
    logic [RES-1:0] w;
    host.pulse;
    host.pulse;
    chk_f(nap, 1'b1);
    host.pulse;
    host.pulse;
    chk_f(sleep, 1'b1);
    host.wake;
    chk_f(sleep, 1'b0);
    host.settle;
    host.frame(1'b0, w);
    chk_w(w, vexp[4]);
    chk_f(oe, 1'b0);
    chk_f(acq, 1'b1);
    $display("t_power done");
  endtask : t_power
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_stream;
    t_power;
    close_out;
  end
  initial begin
    #4000000;
    err_total++;
    close_out;
  end
endmodule : tb_serial_adc_conversion_interface
